// *** core/gtu_defs.svh ***
// Purpose: constants of the general timer unit
// Assumes: 16-bit register port, word indexed
// Notes: fields apply per timer control word
// Functional notes
// - Five 16-bit timers in two modules
// - Timers run alone or chained within module
// - First module modes: timer, gated, counter, incremental
// - Timer mode prescaled clock, counter mode pin
// - Gated mode counts while gate pin active
// - First module timer and gated modes count at most every 4 cycles
// - Software direction, optional direction pin override
// - Incremental mode decodes sensor A and B
// - Core wrap flips core toggle latch, pin optional
// - Core toggle latch can clock auxiliary timers
// - Capture or reload auxiliary timer stops counting
// - Capture role copies core on input edge
// - Reload role loads core on pin or latch
// - Opposite latch reloads give continuous PWM
// - Second module timer mode counts at most every 2 cycles
// - Second module counts prescaled clock or pin
// - Second core wrap flips second toggle latch
// - Second core wraps exported as count clock
// - Second core wrap may reload from capture register
// - Capture register latches second aux on pin
// - Optional clear of second aux on capture
// - Capture also triggered by core input pins
`ifndef GTU_DEFS_SVH
`define GTU_DEFS_SVH
`define GTU_W 16
`define GTU_NT 5
`define GTU_NPIN 11
`define GTU_NEVT 8
// Timer indexes
`define GTU_T_AUXLO 0
`define GTU_T_CORE 1
`define GTU_T_AUXHI 2
`define GTU_T_SAUX 3
`define GTU_T_SCORE 4
// Pin vector layout: inputs, directions, capture pin
`define GTU_P_EUD 5
`define GTU_P_CAPTURE_TRIGGER_PIN 10
// Register word indexes
`define GTU_OFS_CTRL 4'h0
`define GTU_OFS_VAL 4'h5
`define GTU_OFS_CAPTURE_RELOAD_REG 4'ha
`define GTU_OFS_FLAGS 4'hc
// Control word fields
`define GTU_F_MODE 0
`define GTU_F_PS 2
`define GTU_F_RUN 5
`define GTU_F_DOWN 6
`define GTU_F_XDIR 7
`define GTU_F_EDGE 8
`define GTU_F_ROLE 10
`define GTU_F_TRG 12
`define GTU_F_RLDEN 12
`define GTU_F_TOUT 13
`define GTU_F_OTLCLK 14
`define GTU_F_CLRCAP 15
// Least prescale shift: 4 and 2 system cycles
`define GTU_PS1_BASE 4'h2
`define GTU_PS2_BASE 4'h1
`define GTU_RST_STATE '0
`endif

// *** core/gtu_pkg.sv ***
// Purpose: types of the general timer unit
// Assumes: gtu_defs.svh sizes
// Notes: whole unit state is one packed struct
`include "gtu_defs.svh"
package gtu_pkg;
  // Counting modes of one timer
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_GATED = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_INCR = 2'h3
  } gtu_mode_t;
  // Auxiliary timer roles
  typedef enum logic [1:0] {
    ROLE_NORMAL = 2'h0,
    ROLE_CAPTURE = 2'h1,
    ROLE_RELOAD = 2'h2
  } gtu_role_t;
  // Complete register state
  typedef struct packed {
    logic [`GTU_NT-1:0][`GTU_W-1:0] ctrl;
    logic [`GTU_NT-1:0][`GTU_W-1:0] val;
    logic [`GTU_W-1:0] capture_reload_reg;
    logic [`GTU_NPIN-1:0] s1;
    logic [`GTU_NPIN-1:0] s2;
    logic [`GTU_NPIN-1:0] pv;
    logic [`GTU_W-1:0] base;
    logic otl3;
    logic otl6;
    logic pin3;
    logic pin6;
    logic [`GTU_NEVT-1:0] evt;
    logic [`GTU_NEVT-1:0] flags;
    logic [`GTU_W-1:0] rdata;
  } gtu_state_t;
endpackage

// *** core/gtu_general_timer_unit.sv ***
// Purpose: five-timer unit in two modules
// Assumes: pins asynchronous, bus on I_SYS_CLK
// Notes: read data appear one cycle after strobe
//
// Chosen here: the register offsets and the plain strobed port.
`include "gtu_defs.svh"
module gtu_general_timer_unit (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [`GTU_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`GTU_W-1:0] O_RDATA,
  // Timer pins
  input wire logic [`GTU_NT-1:0] I_TIN,
  input wire logic [`GTU_NT-1:0] I_EUD,
  input wire logic I_CAPTURE_TRIGGER_PIN,
  output logic O_CORE_TOGGLE,
  output logic O_SECOND_TOGGLE,
  // Events
  output logic O_CC_CLK,
  output logic [`GTU_NEVT-1:0] O_EVT
);
  // Registered and next state
  gtu_pkg::gtu_state_t st;
  gtu_pkg::gtu_state_t nx;
  // Per-cycle decisions
  logic [`GTU_NT-1:0] step_w;
  logic [`GTU_NT-1:0] dn_w;
  logic [`GTU_NT-1:0] wrap_w;
  logic [`GTU_NPIN-1:0] rise_w;
  logic [`GTU_NPIN-1:0] fall_w;
  logic rld_lo_w;
  logic rld_hi_w;
  logic cap_lo_w;
  logic cap_hi_w;
  logic cap_c_w;
  logic [`GTU_W-1:0] rd_w;

  // Prescaler tap: true once per 2^n cycles
  function automatic logic pre_hit(input logic [`GTU_W-1:0] b, input logic [3:0] n);
    logic [`GTU_W-1:0] m;
    m = (16'h0001 << n) - 16'h0001;
    return (b & m) == m;
  endfunction

  // Edge select: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
    return (sel[0] & r) | (sel[1] & f);
  endfunction

  // Wrap when stepping past the end of range
  function automatic logic wraps(input logic s, input logic d, input logic [`GTU_W-1:0] v);
    return s & (d ? (v == 16'h0000) : (v == 16'hffff));
  endfunction

  // Mode of a timer; second module knows timer and counter only
  function automatic gtu_pkg::gtu_mode_t mode_of(input int i, input logic [`GTU_W-1:0] c);
    gtu_pkg::gtu_mode_t m;
    m = gtu_pkg::gtu_mode_t'(c[`GTU_F_MODE +: 2]);
    if (i >= `GTU_T_SAUX && m != gtu_pkg::MODE_COUNTER) begin
      m = gtu_pkg::MODE_TIMER;
    end
    return m;
  endfunction

  // Reload trigger: pin edge, latch rise or latch fall
  function automatic logic trig_hit(input logic [`GTU_W-1:0] c, input logic r, input logic f,
                                    input logic w, input logic otl);
    logic t;
    t = 1'b0;
    if (c[`GTU_F_TRG +: 2] == 2'h0) begin
      t = edge_hit(r, f, c[`GTU_F_EDGE +: 2]);
    end else if (c[`GTU_F_TRG +: 2] == 2'h1) begin
      t = w & ~otl;
    end else if (c[`GTU_F_TRG +: 2] == 2'h2) begin
      t = w & otl;
    end
    return t;
  endfunction

  // Role field of an auxiliary timer
  function automatic gtu_pkg::gtu_role_t role_of(input logic [`GTU_W-1:0] c);
    return gtu_pkg::gtu_role_t'(c[`GTU_F_ROLE +: 2]);
  endfunction

  // Next state of the whole unit
  always_comb begin
    nx = st;
    // Two-stage synchroniser, third stage for edges
    nx.s1 = {I_CAPTURE_TRIGGER_PIN, I_EUD, I_TIN};
    nx.s2 = st.s1;
    nx.pv = st.s2;
    rise_w = st.s2 & ~st.pv;
    fall_w = ~st.s2 & st.pv;
    // Shared prescaler counter
    nx.base = st.base + 16'h0001;
    step_w = 5'h00;
    dn_w = 5'h00;
    wrap_w = 5'h00;
    rd_w = 16'h0000;
    // Raw step and direction per timer
    for (int i = 0; i < `GTU_NT; i++) begin
      dn_w[i] = st.ctrl[i][`GTU_F_DOWN] ^ (st.ctrl[i][`GTU_F_XDIR] & st.s2[`GTU_P_EUD + i]);
      case (mode_of(i, st.ctrl[i]))
        gtu_pkg::MODE_TIMER: begin
          // First module from 4 cycles, second from 2
          step_w[i] = pre_hit(st.base, (i < `GTU_T_SAUX ? `GTU_PS1_BASE : `GTU_PS2_BASE)
                              + {1'b0, st.ctrl[i][`GTU_F_PS +: 3]});
        end
        gtu_pkg::MODE_GATED: begin
          // Gate level polarity from edge field bit 0
          step_w[i] = pre_hit(st.base, `GTU_PS1_BASE + {1'b0, st.ctrl[i][`GTU_F_PS +: 3]})
                      & (st.s2[i] == st.ctrl[i][`GTU_F_EDGE]);
        end
        gtu_pkg::MODE_COUNTER: begin
          // Input pin edges clock the timer
          step_w[i] = edge_hit(rise_w[i], fall_w[i], st.ctrl[i][`GTU_F_EDGE +: 2]);
        end
        default: begin
          // Quadrature: every A or B edge, up when A now differs from B before
          step_w[i] = rise_w[i] | fall_w[i] | rise_w[`GTU_P_EUD + i] | fall_w[`GTU_P_EUD + i];
          dn_w[i] = ~(st.s2[i] ^ st.pv[`GTU_P_EUD + i]) ^ st.ctrl[i][`GTU_F_DOWN];
        end
      endcase
      step_w[i] = step_w[i] & st.ctrl[i][`GTU_F_RUN];
    end
    // Chaining off toggle latches: a latch change is a wrap of the module's core or second core
    if (st.ctrl[`GTU_T_AUXLO][`GTU_F_OTLCLK]) begin
      step_w[`GTU_T_AUXLO] = st.ctrl[`GTU_T_AUXLO][`GTU_F_RUN]
        & wraps(step_w[`GTU_T_CORE], dn_w[`GTU_T_CORE], st.val[`GTU_T_CORE]);
    end
    if (st.ctrl[`GTU_T_AUXHI][`GTU_F_OTLCLK]) begin
      step_w[`GTU_T_AUXHI] = st.ctrl[`GTU_T_AUXHI][`GTU_F_RUN]
        & wraps(step_w[`GTU_T_CORE], dn_w[`GTU_T_CORE], st.val[`GTU_T_CORE]);
    end
    if (st.ctrl[`GTU_T_SAUX][`GTU_F_OTLCLK]) begin
      step_w[`GTU_T_SAUX] = st.ctrl[`GTU_T_SAUX][`GTU_F_RUN]
        & wraps(step_w[`GTU_T_SCORE], dn_w[`GTU_T_SCORE], st.val[`GTU_T_SCORE]);
    end
    // Aux timers used as capture or reload registers stand still
    if (role_of(st.ctrl[`GTU_T_AUXLO]) != gtu_pkg::ROLE_NORMAL) begin
      step_w[`GTU_T_AUXLO] = 1'b0;
    end
    if (role_of(st.ctrl[`GTU_T_AUXHI]) != gtu_pkg::ROLE_NORMAL) begin
      step_w[`GTU_T_AUXHI] = 1'b0;
    end
    // Count and wrap, 16-bit modulo arithmetic
    for (int i = 0; i < `GTU_NT; i++) begin
      wrap_w[i] = wraps(step_w[i], dn_w[i], st.val[i]);
      if (step_w[i]) begin
        nx.val[i] = dn_w[i] ? st.val[i] - 16'h0001 : st.val[i] + 16'h0001;
      end
    end
    // Toggle latches flip on each wrap
    nx.otl3 = st.otl3 ^ wrap_w[`GTU_T_CORE];
    nx.otl6 = st.otl6 ^ wrap_w[`GTU_T_SCORE];
    // Core reload from aux; low aux wins if both fire
    rld_lo_w = (role_of(st.ctrl[`GTU_T_AUXLO]) == gtu_pkg::ROLE_RELOAD)
      & trig_hit(st.ctrl[`GTU_T_AUXLO], rise_w[`GTU_T_AUXLO], fall_w[`GTU_T_AUXLO],
                 wrap_w[`GTU_T_CORE], st.otl3);
    rld_hi_w = (role_of(st.ctrl[`GTU_T_AUXHI]) == gtu_pkg::ROLE_RELOAD)
      & trig_hit(st.ctrl[`GTU_T_AUXHI], rise_w[`GTU_T_AUXHI], fall_w[`GTU_T_AUXHI],
                 wrap_w[`GTU_T_CORE], st.otl3);
    // Opposite-latch reloads replace the wrap value: hardware PWM
    if (rld_lo_w) begin
      nx.val[`GTU_T_CORE] = st.val[`GTU_T_AUXLO];
    end else if (rld_hi_w) begin
      nx.val[`GTU_T_CORE] = st.val[`GTU_T_AUXHI];
    end
    // Capture of core value on the aux input pin
    cap_lo_w = (role_of(st.ctrl[`GTU_T_AUXLO]) == gtu_pkg::ROLE_CAPTURE)
      & edge_hit(rise_w[`GTU_T_AUXLO], fall_w[`GTU_T_AUXLO], st.ctrl[`GTU_T_AUXLO][`GTU_F_EDGE +: 2]);
    cap_hi_w = (role_of(st.ctrl[`GTU_T_AUXHI]) == gtu_pkg::ROLE_CAPTURE)
      & edge_hit(rise_w[`GTU_T_AUXHI], fall_w[`GTU_T_AUXHI], st.ctrl[`GTU_T_AUXHI][`GTU_F_EDGE +: 2]);
    if (cap_lo_w) begin
      nx.val[`GTU_T_AUXLO] = st.val[`GTU_T_CORE];
    end
    if (cap_hi_w) begin
      nx.val[`GTU_T_AUXHI] = st.val[`GTU_T_CORE];
    end
    // Second core reload from capture register on wrap
    if (wrap_w[`GTU_T_SCORE] && st.ctrl[`GTU_T_SCORE][`GTU_F_RLDEN]) begin
      nx.val[`GTU_T_SCORE] = st.capture_reload_reg;
    end
    // Capture source: capture pin, core input or core direction pin
    cap_c_w = 1'b0;
    if (st.ctrl[`GTU_T_SAUX][`GTU_F_ROLE +: 2] == 2'h1) begin
      cap_c_w = edge_hit(rise_w[`GTU_P_CAPTURE_TRIGGER_PIN], fall_w[`GTU_P_CAPTURE_TRIGGER_PIN],
                         st.ctrl[`GTU_T_SAUX][`GTU_F_TRG +: 2]);
    end else if (st.ctrl[`GTU_T_SAUX][`GTU_F_ROLE +: 2] == 2'h2) begin
      cap_c_w = rise_w[`GTU_T_CORE] | fall_w[`GTU_T_CORE];
    end else if (st.ctrl[`GTU_T_SAUX][`GTU_F_ROLE +: 2] == 2'h3) begin
      cap_c_w = rise_w[`GTU_P_EUD + 1] | fall_w[`GTU_P_EUD + 1];
    end
    if (cap_c_w) begin
      nx.capture_reload_reg = st.val[`GTU_T_SAUX];
      // Clear beats a count in the same cycle
      if (st.ctrl[`GTU_T_SAUX][`GTU_F_CLRCAP]) begin
        nx.val[`GTU_T_SAUX] = 16'h0000;
      end
    end
    // One-cycle events: wraps then captures
    nx.evt = {cap_c_w, cap_hi_w, cap_lo_w, wrap_w};
    // Toggle pins follow the new latch state when enabled
    nx.pin3 = nx.otl3 & st.ctrl[`GTU_T_CORE][`GTU_F_TOUT];
    nx.pin6 = nx.otl6 & st.ctrl[`GTU_T_SCORE][`GTU_F_TOUT];
    // Read decode, unmapped words read zero
    if (I_ADDR < `GTU_OFS_VAL) begin
      rd_w = st.ctrl[I_ADDR[2:0]];
    end else if (I_ADDR < `GTU_OFS_CAPTURE_RELOAD_REG) begin
      rd_w = st.val[3'(I_ADDR - `GTU_OFS_VAL)];
    end else if (I_ADDR == `GTU_OFS_CAPTURE_RELOAD_REG) begin
      rd_w = st.capture_reload_reg;
    end else if (I_ADDR == `GTU_OFS_FLAGS) begin
      rd_w = {8'h00, st.flags};
    end
    nx.rdata = I_RD ? rd_w : 16'h0000;
    // Software writes override hardware updates of the same word, except flag sets
    if (I_WR) begin
      if (I_ADDR < `GTU_OFS_VAL) begin
        nx.ctrl[I_ADDR[2:0]] = I_WDATA;
      end else if (I_ADDR < `GTU_OFS_CAPTURE_RELOAD_REG) begin
        nx.val[3'(I_ADDR - `GTU_OFS_VAL)] = I_WDATA;
      end else if (I_ADDR == `GTU_OFS_CAPTURE_RELOAD_REG) begin
        nx.capture_reload_reg = I_WDATA;
      end else if (I_ADDR == `GTU_OFS_FLAGS) begin
        // Write one to clear
        nx.flags = st.flags & ~I_WDATA[`GTU_NEVT-1:0];
      end
    end
    // New events set after the clear, so set wins
    nx.flags = nx.flags | nx.evt;
  end

  // State register
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= `GTU_RST_STATE;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from flip-flops
  assign O_RDATA = st.rdata;
  assign O_CORE_TOGGLE = st.pin3;
  assign O_SECOND_TOGGLE = st.pin6;
  assign O_CC_CLK = st.evt[`GTU_T_SCORE];
  assign O_EVT = st.evt;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  // Writes that would mask a hardware update
  logic wr_core;
  logic wr_saux;
  logic wr_cap;
  assign wr_core = I_WR && (I_ADDR == `GTU_OFS_VAL + 4'h1);
  assign wr_saux = I_WR && (I_ADDR == `GTU_OFS_VAL + 4'h3);
  assign wr_cap = I_WR && (I_ADDR == `GTU_OFS_CAPTURE_RELOAD_REG);

  a_core_toggle_flip:
    assert property ($changed(st.otl3) == st.evt[`GTU_T_CORE])
    else $error("core toggle latch and core wrap disagree");
  a_second_toggle_flip:
    assert property ($changed(st.otl6) == st.evt[`GTU_T_SCORE])
    else $error("second toggle latch and second wrap disagree");
  a_cc_clk_export:
    assert property (O_CC_CLK |-> $changed(st.otl6) ##1 !O_CC_CLK)
    else $error("exported clock not tied to second wrap");
  a_first_resolution:
    assert property (step_w[`GTU_T_CORE] && st.ctrl[`GTU_T_CORE][1:0] == 2'h0 |-> st.base[1:0] == 2'h3)
    else $error("core timer stepped off the 4-cycle grid");
  a_second_resolution:
    assert property (step_w[`GTU_T_SCORE] && st.ctrl[`GTU_T_SCORE][1:0] == 2'h0 |-> st.base[0])
    else $error("second core stepped off the 2-cycle grid");
  a_aux_stopped:
    assert property (st.ctrl[`GTU_T_AUXLO][`GTU_F_ROLE +: 2] != 2'h0 && !cap_lo_w
                     && !(I_WR && I_ADDR == `GTU_OFS_VAL) |=> $stable(st.val[`GTU_T_AUXLO]))
    else $error("aux timer counted while in capture or reload role");
  a_core_reload:
    assert property (rld_lo_w && !wr_core |=> st.val[`GTU_T_CORE] == $past(st.val[`GTU_T_AUXLO]))
    else $error("core not reloaded from low aux");
  a_up_wrap:
    assert property (step_w[`GTU_T_CORE] && !dn_w[`GTU_T_CORE] && st.val[`GTU_T_CORE] == 16'hffff
                     && !rld_lo_w && !rld_hi_w && !wr_core |=> st.val[`GTU_T_CORE] == 16'h0000
                     && st.evt[`GTU_T_CORE])
    else $error("core did not wrap to zero with event");
  a_capture_reload_reg_capture:
    assert property (cap_c_w && !wr_cap |=> st.capture_reload_reg == $past(st.val[`GTU_T_SAUX]) && st.evt[7])
    else $error("capture register missed second aux value");
  a_clear_capture:
    assert property (cap_c_w && st.ctrl[`GTU_T_SAUX][`GTU_F_CLRCAP] && !wr_saux
                     |=> st.val[`GTU_T_SAUX] == 16'h0000)
    else $error("second aux not cleared on capture");
  a_flag_sticky:
    assert property (!(I_WR && I_ADDR == `GTU_OFS_FLAGS) |=> (st.flags & $past(st.flags)) == $past(st.flags))
    else $error("sticky flag dropped without a clear");

  c_pwm_reload: cover property (rld_lo_w ##[1:200] rld_hi_w);
  c_capture_reload_reg_capture: cover property (cap_c_w);
  c_incr_down: cover property (step_w[`GTU_T_CORE] && dn_w[`GTU_T_CORE] && st.ctrl[`GTU_T_CORE][1:0] == 2'h3);
  c_second_reload: cover property (wrap_w[`GTU_T_SCORE] && st.ctrl[`GTU_T_SCORE][`GTU_F_RLDEN]);
endmodule

// *** test/gtu_sensor_model.sv ***
// Purpose: position sensor and event sources on the timer pins
// Assumes: pin index order of the unit's pin vector
// Notes: each level is held two cycles so the synchroniser sees it
`include "gtu_defs.svh"
module gtu_sensor_model (
  // Clock
  input wire logic i_clk,
  // Pins toward the unit
  output logic [`GTU_NT-1:0] o_tin,
  output logic [`GTU_NT-1:0] o_eud,
  output logic o_capture_trigger_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Inputs, directions, capture pin in one vector
  logic [`GTU_NPIN-1:0] pins = '0;
  assign o_tin = pins[`GTU_NT-1:0];
  assign o_eud = pins[`GTU_P_EUD+`GTU_NT-1:`GTU_P_EUD];
  assign o_capture_trigger_pin = pins[`GTU_P_CAPTURE_TRIGGER_PIN];
  // Drive one pin after an edge, then hold it
  task automatic set_pin(input int idx, input logic v);
    @(posedge i_clk);
    pins[idx] <= v;
    repeat (2) @(posedge i_clk);
  endtask
  // Quadrature steps, one edge of A or B per step
  task automatic quad(input int idx, input int steps, input bit rev);
    bit chg_a;
    for (int s = 0; s < steps; s++) begin
      chg_a = (pins[idx] == pins[idx+`GTU_P_EUD]) ^ rev;
      set_pin(chg_a ? idx : idx + `GTU_P_EUD, chg_a ? ~pins[idx] : ~pins[idx+`GTU_P_EUD]);
    end
  endtask
endmodule

// *** test/gtu_general_timer_unit_tb.sv ***
// Purpose: self-checking bench of the general timer unit
// Assumes: sensor model drives every timer pin
// Notes: expectations come from integer sums; only the cc clock check starts from the unit's own pulse count
`include "gtu_defs.svh"
`define CHK(nm, e, g) begin if ((g) !== (e)) begin $display("ERROR %s expected %h seen %h", nm, e, g); fails++; end samples_checked++; end
module gtu_general_timer_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and register port
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [`GTU_W-1:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`GTU_W-1:0] rdata;
  // Pins and events
  logic [`GTU_NT-1:0] tin;
  logic [`GTU_NT-1:0] eud;
  logic capture_trigger_pin;
  logic core_tgl;
  logic second_tgl;
  logic cc_clk;
  logic [`GTU_NEVT-1:0] evt;
  // Score and model state
  int fails = 0;
  int samples_checked = 0;
  int cc_pulses = 0;
  int m;
  logic [`GTU_W-1:0] got;
  logic [`GTU_W-1:0] r;
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // Count exported wrap pulses, one cycle each
  always @(posedge sys_clk) if (cc_clk === 1'b1) cc_pulses++;
  gtu_general_timer_unit i_gtu_general_timer_unit (
    .I_SYS_CLK(sys_clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_TIN(tin), .I_EUD(eud), .I_CAPTURE_TRIGGER_PIN(capture_trigger_pin), .O_CORE_TOGGLE(core_tgl),
    .O_SECOND_TOGGLE(second_tgl), .O_CC_CLK(cc_clk), .O_EVT(evt));
  gtu_sensor_model i_gtu_sensor_model (.i_clk(sys_clk), .o_tin(tin), .o_eud(eud), .o_capture_trigger_pin(capture_trigger_pin));
  // One-cycle write
  task automatic wr_reg(input logic [3:0] a, input logic [`GTU_W-1:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic chk_reg(input string nm, input logic [3:0] a, input logic [`GTU_W-1:0] e);
    rd_reg(a);
    `CHK(nm, e, got)
  endtask
  task automatic pin(input int i, input logic v);
    i_gtu_sensor_model.set_pin(i, v);
  endtask
  task automatic pulse(input int i);
    pin(i, 1'b1);
    pin(i, 1'b0);
  endtask
  // Verdict, the only end of the run
  task automatic final_report();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the run length
  initial begin
    #500us;
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(32'h3b98));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values; unmapped write must vanish
    wr_reg(4'hb, 16'hffff);
    for (int a = 0; a < 16; a++) chk_reg("reset word", 4'(a), 16'h0);
    // Stopped timers keep random 16-bit values
    for (int i = 0; i < `GTU_NT; i++) begin
      r = 16'($urandom());
      wr_reg(4'h5 + 4'(i), r);
      chk_reg("value word", 4'h5 + 4'(i), r);
    end
    // Core counts pin edges up through all ones
    wr_reg(4'h6, 16'hfffe);
    wr_reg(4'h1, 16'h21e2);
    pin(6, 1'b1);
    repeat (3) pulse(1);
    chk_reg("core up", 4'h6, 16'h0001);
    `CHK("core toggle", 1'b1, core_tgl)
    pin(6, 1'b0);
    repeat (2) pulse(1);
    chk_reg("core down", 4'h6, 16'hffff);
    `CHK("core toggle back", 1'b0, core_tgl)
    chk_reg("flags", 4'hc, 16'h0002);
    wr_reg(4'hc, 16'h00ff);
    chk_reg("flags cleared", 4'hc, 16'h0);
    // Gated timer: shut while pin low, one count per 4 cycles when open
    wr_reg(4'h5, 16'h0);
    wr_reg(4'h0, 16'h0121);
    repeat (160) @(posedge sys_clk);
    chk_reg("gate shut", 4'h5, 16'h0);
    pin(0, 1'b1);
    repeat (157) @(posedge sys_clk);
    rd_reg(4'h5);
    `CHK("gated rate", 1'b1, got >= 16'd38 && got <= 16'd41)
    pin(0, 1'b0);
    // Second core timer, one count per 2 cycles
    wr_reg(4'h9, 16'h0);
    wr_reg(4'h4, 16'h0020);
    repeat (100) @(posedge sys_clk);
    rd_reg(4'h9);
    `CHK("second rate", 1'b1, got >= 16'd49 && got <= 16'd53)
    wr_reg(4'h4, 16'h0);
    // Incremental mode follows sensor position
    wr_reg(4'h6, 16'h0);
    wr_reg(4'h1, 16'h0023);
    m = 0;
    i_gtu_sensor_model.quad(1, 12, 1'b0);
    m += 12;
    i_gtu_sensor_model.quad(1, 5, 1'b1);
    m -= 5;
    chk_reg("position", 4'h6, 16'(m));
    // Capture role ignores run and copies core on pin edge
    wr_reg(4'h1, 16'h0);
    r = 16'($urandom());
    wr_reg(4'h6, r);
    wr_reg(4'h7, 16'h0);
    wr_reg(4'h2, 16'h0520);
    pulse(2);
    repeat (20) @(posedge sys_clk);
    chk_reg("capture", 4'h7, r);
    // Reload of core from aux by pin edge
    r = 16'($urandom());
    wr_reg(4'h5, r);
    wr_reg(4'h0, 16'h0900);
    pulse(0);
    chk_reg("pin reload", 4'h6, r);
    // Reload on latch rise replaces the wrap value
    wr_reg(4'h0, 16'h1800);
    wr_reg(4'h6, 16'hffff);
    wr_reg(4'h1, 16'h0122);
    pulse(1);
    chk_reg("latch reload", 4'h6, r);
    wr_reg(4'h1, 16'h0);
    // Capture pin latches second aux, then clears it
    r = 16'($urandom());
    wr_reg(4'h8, r);
    wr_reg(4'h3, 16'h9400);
    pulse(10);
    chk_reg("capture_reload_reg", 4'ha, r);
    chk_reg("cleared", 4'h8, 16'h0);
    // Capture from core input pin edge
    r = 16'($urandom());
    wr_reg(4'h8, r);
    wr_reg(4'h3, 16'h0800);
    pin(1, 1'b1);
    chk_reg("core pin capture", 4'ha, r);
    // Second core wrap reloads, toggles and exports a clock
    wr_reg(4'h9, 16'hffff);
    wr_reg(4'h4, 16'h3122);
    m = cc_pulses;
    pulse(4);
    chk_reg("second reload", 4'h9, r);
    `CHK("cc clock", 16'(m + 1), 16'(cc_pulses))
    `CHK("second toggle", 1'b1, second_tgl)
    chk_reg("flags all", 4'hc, 16'h00d2);
    `CHK("event idle", 8'h00, evt)
    final_report();
  end
endmodule
